//--- ppbm_pkg.sv
// Package for the parallel port and bus multiplexer block.
// Assumes a single 100 MHz core clock domain; also holds the register bus addresses and config bit positions.
package ppbm_pkg;
	localparam int PPBM_PORT_W = 8;
	localparam int PPBM_NPORTS = 4;
	localparam logic [7:0] PPBM_LATCH_RST = 8'hFF;
	localparam logic [7:0] PPBM_ALL_ONES = 8'hFF;
	localparam logic [7:0] PPBM_ALL_ZERO = 8'h00;
	// Strong transition pull-up time; one oscillator period is one core clock
	localparam int PPBM_OSC_PERIOD_NS = 10;
	localparam int PPBM_XPU_TIME_NS = 2 * PPBM_OSC_PERIOD_NS;
	localparam int PPBM_CLK_NS = 10;
	localparam int PPBM_XPU_CYC = (PPBM_XPU_TIME_NS + PPBM_CLK_NS - 1) / PPBM_CLK_NS;
	localparam logic [1:0] PPBM_XPU_LOAD = 2'(PPBM_XPU_CYC);
	// Wishbone register byte addresses
	localparam logic [4:0] PPBM_A_PORT0 = 5'h00;
	localparam logic [4:0] PPBM_A_PORT1 = 5'h04;
	localparam logic [4:0] PPBM_A_PORT2 = 5'h08;
	localparam logic [4:0] PPBM_A_PORT3 = 5'h0C;
	localparam logic [4:0] PPBM_A_CFG = 5'h10;
	// Config register bit positions
	localparam int PPBM_CFG_PAGE = 0;
	localparam int PPBM_CFG_RD_LO = 1;
	localparam int PPBM_CFG_RD_HI = 2;
	// Address width selects
	typedef enum logic [1:0] {PPBM_AW8, PPBM_AW16, PPBM_AW17, PPBM_AW18} ppbm_aw_t;
	// Port access op from the core
	typedef enum logic [2:0] {
		PPBM_OP_NONE, PPBM_OP_WRITE, PPBM_OP_RD_PIN, PPBM_OP_RMW_BYTE, PPBM_OP_RMW_BIT
	} ppbm_op_t;
	typedef enum logic [1:0] {PPBM_RMW_AND, PPBM_RMW_OR, PPBM_RMW_XOR, PPBM_RMW_LOAD} ppbm_alu_t;
	typedef enum logic [1:0] {PPBM_XK_FETCH, PPBM_XK_DREAD, PPBM_XK_DWRITE} ppbm_xkind_t;
	typedef struct packed {
		logic valid;
		ppbm_op_t op;
		logic [1:0] port;
		logic [2:0] bit_sel;
		logic bit_val;
		ppbm_alu_t alu;
		logic [7:0] data;
	} ppbm_req_t;
	typedef struct packed {
		logic start;
		ppbm_xkind_t kind;
		ppbm_aw_t aw;
		logic [17:0] addr;
		logic [7:0] wdata;
	} ppbm_xreq_t;
	typedef enum logic [2:0] {PPBM_S_IDLE, PPBM_S_ALE, PPBM_S_ADDR, PPBM_S_STROBE,
		PPBM_S_END} ppbm_xstate_t;
	typedef struct packed {
		logic [3:0][7:0] latch;
		logic [3:0][7:0] pin_m;
		logic [3:0][7:0] pin_s;
		logic [1:0][7:0][1:0] xpu_cnt;
		logic [1:0][7:0] keeper;
		logic [3:0][7:0] prev_latch;
		logic cfg_page;
		logic cfg_rd_lo;
		logic cfg_rd_hi;
		logic page_mode;
		ppbm_xstate_t xst;
		ppbm_xreq_t xr;
		logic [7:0] rd_data;
		logic rd_valid;
		logic [7:0] x_rdata;
		logic x_done;
		logic ale;
		logic program_store_strobe_n_n;
		logic rd_n;
		logic wr_n;
		logic [7:0] p0_o;
		logic [7:0] p0_oe;
		logic [7:0] p0_pu;
		logic [7:0] p2_o;
		logic [7:0] p2_oe;
		logic [7:0] p1_o;
		logic [7:0] p3_o;
		logic [7:0] p1_xpu;
		logic [7:0] p3_xpu;
		logic [7:0] p1_keep;
		logic [7:0] p3_keep;
		logic [7:0] p1_adr;
		logic [7:0] p3_adr;
		logic [1:0] a_hi;
		logic [31:0] wb_dat;
		logic wb_ack;
	} ppbm_state_t;
endpackage : ppbm_pkg

//--- ppbm_top.sv
// Four 8-bit parallel ports with an external address/data bus multiplexer.
// Operation
// - CPU write loads internal bus value into the port output latch.
// - Port read returns latch or pins, chosen by the access kind.
// - Logical, jump, complement, inc/dec and bit ops read the latch.
// - Bit move/clear/set reads all 8 latch bits, rewrites whole byte.
// - Each port line is independently input or output.
// - Latch one turns off pull-down so the pin can be input.
// - Quasi ports with latch one follow the alternate-function output.
// - External cycles drive bus ports from address/data, not latch; 8-bit cycles leave the high byte on its latch.
// - Bus ports give no general I/O while acting as bus.
// - Low-byte port pulls up only for bus ones; else open-drain.
// - Reset sets every latch bit to one; writing one restores input.
// - Read-modify-write updates latch at end; quasi-port pins change next cycle, bus-port pins with the latch.
// - Strong pull-up on for two oscillator periods after latch rises.
// - Pin sensed high enables keeper pull-up until sensed low.
// - Every external bus cycle writes FFh into the low-byte latch.
// - High-byte latch unchanged by bus; pins show it when idle.
// - Non-page: high=upper addr, low=addr/data; page: high=upper addr/data, low=low addr.
// - Data-carrying port is high impedance while receiving data.
// - Fetch uses program strobe; reads by config bits; writes use write strobe.
// - Data access address is 8, 16, 17 or 18 bits wide.
// - Address byte is valid while address latch enable is high.
// - Write data valid before write strobe falls, held until release.
// Assumes the core issues one port access or bus request at a time.
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ppbm_top
	import ppbm_pkg::*;
(
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic RESET_I,
	input wire logic CLK_EN_I,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [4:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Core port access
	input wire ppbm_pkg::ppbm_req_t PORT_REQ_I,
	output logic [7:0] PORT_RDATA_O,
	output logic PORT_RVALID_O,
	// Core external bus request
	input wire ppbm_pkg::ppbm_xreq_t XBUS_REQ_I,
	input wire logic PAGE_MODE_I,
	output logic [7:0] XBUS_RDATA_O,
	output logic XBUS_DONE_O,
	// Alternate function outputs of quasi ports
	input wire logic [7:0] ALT1_OUT_I,
	input wire logic [7:0] ALT3_OUT_I,
	// Pins
	input wire logic [7:0] LOW_BYTE_BUS_PORT_I,
	output logic [7:0] LOW_BYTE_BUS_PORT_O,
	output logic [7:0] LOW_BYTE_BUS_PORT_OE_O,
	output logic [7:0] LOW_BYTE_PULLUP_O,
	input wire logic [7:0] QUASI_PORT_ONE_I,
	output logic [7:0] QUASI_PORT_ONE_O,
	output logic [7:0] QUASI_PORT_ONE_OE_O,
	output logic [7:0] QUASI_ONE_TRANSITION_PULLUP_O,
	output logic [7:0] QUASI_ONE_KEEPER_PULLUP_O,
	input wire logic [7:0] HIGH_BYTE_BUS_PORT_I,
	output logic [7:0] HIGH_BYTE_BUS_PORT_O,
	output logic [7:0] HIGH_BYTE_BUS_PORT_OE_O,
	input wire logic [7:0] QUASI_PORT_THREE_I,
	output logic [7:0] QUASI_PORT_THREE_O,
	output logic [7:0] QUASI_PORT_THREE_OE_O,
	output logic [7:0] QUASI_THREE_TRANSITION_PULLUP_O,
	output logic [7:0] QUASI_THREE_KEEPER_PULLUP_O,
	output logic [1:0] EXT_ADDR_HI_O,
	output logic ALE_O,
	output logic PROGRAM_STORE_STROBE_N_O,
	output logic READ_STROBE_N_O,
	output logic WRITE_STROBE_N_O
);
	import ppbm_pkg::*;

	ppbm_state_t s;
	ppbm_state_t next_s;
	logic [3:0][7:0] pins_raw;
	logic [7:0] cur;
	logic [7:0] mod;
	logic [7:0] bit_mask;
	logic bus_act;
	logic data_phase;
	logic read_strobe_sel;
	logic wb_hit;

	assign pins_raw = {QUASI_PORT_THREE_I, HIGH_BYTE_BUS_PORT_I, QUASI_PORT_ONE_I,
		LOW_BYTE_BUS_PORT_I};

	always_comb begin
		next_s = s;
		cur = s.latch[PORT_REQ_I.port];
		mod = cur;
		bit_mask = 8'h01 << PORT_REQ_I.bit_sel;
		read_strobe_sel = 1'b0;
		wb_hit = WB_CYC_I && WB_STB_I && !s.wb_ack;
		// Two-stage pin synchroniser; only the second stage is read
		next_s.pin_m = pins_raw;
		next_s.pin_s = s.pin_m;
		next_s.rd_valid = 1'b0;
		next_s.x_done = 1'b0;
		next_s.wb_ack = 1'b0;
		// Core port access
		if (PORT_REQ_I.valid) begin
			case (PORT_REQ_I.op)
				PPBM_OP_WRITE: begin
					next_s.latch[PORT_REQ_I.port] = PORT_REQ_I.data;
				end
				PPBM_OP_RD_PIN: begin
					next_s.rd_data = s.pin_s[PORT_REQ_I.port];
					next_s.rd_valid = 1'b1;
				end
				PPBM_OP_RMW_BYTE: begin
					case (PORT_REQ_I.alu)
						PPBM_RMW_AND: mod = cur & PORT_REQ_I.data;
						PPBM_RMW_OR: mod = cur | PORT_REQ_I.data;
						PPBM_RMW_XOR: mod = cur ^ PORT_REQ_I.data;
						default: mod = PORT_REQ_I.data;
					endcase
					next_s.rd_data = cur;
					next_s.rd_valid = 1'b1;
					next_s.latch[PORT_REQ_I.port] = mod;
				end
				PPBM_OP_RMW_BIT: begin
					mod = PORT_REQ_I.bit_val ? (cur | bit_mask) : (cur & ~bit_mask);
					next_s.rd_data = cur;
					next_s.rd_valid = 1'b1;
					next_s.latch[PORT_REQ_I.port] = mod;
				end
				default: begin
				end
			endcase
		end
		// Wishbone: ports at 0..C, config at 10; unmapped reads zero, still acked
		if (wb_hit) begin
			next_s.wb_ack = 1'b1;
			next_s.wb_dat = 32'h0000_0000;
			case (WB_ADR_I)
				PPBM_A_PORT0, PPBM_A_PORT1, PPBM_A_PORT2, PPBM_A_PORT3: begin
					if (WB_WE_I && WB_SEL_I[0]) begin
						next_s.latch[WB_ADR_I[3:2]] = WB_DAT_I[7:0];
					end
					next_s.wb_dat[7:0] = s.latch[WB_ADR_I[3:2]];
				end
				PPBM_A_CFG: begin
					if (WB_WE_I && WB_SEL_I[0]) begin
						next_s.cfg_page = WB_DAT_I[PPBM_CFG_PAGE];
						next_s.cfg_rd_lo = WB_DAT_I[PPBM_CFG_RD_LO];
						next_s.cfg_rd_hi = WB_DAT_I[PPBM_CFG_RD_HI];
					end
					next_s.wb_dat[PPBM_CFG_PAGE] = s.page_mode;
					next_s.wb_dat[PPBM_CFG_RD_LO] = s.cfg_rd_lo;
					next_s.wb_dat[PPBM_CFG_RD_HI] = s.cfg_rd_hi;
				end
				default: begin
				end
			endcase
		end
		// External bus sequencer
		case (s.xst)
			PPBM_S_IDLE: begin
				if (XBUS_REQ_I.start) begin
					next_s.xr = XBUS_REQ_I;
					next_s.page_mode = PAGE_MODE_I | s.cfg_page;
					next_s.latch[0] = PPBM_ALL_ONES;
					next_s.xst = PPBM_S_ALE;
				end
			end
			PPBM_S_ALE: next_s.xst = PPBM_S_ADDR;
			PPBM_S_ADDR: next_s.xst = PPBM_S_STROBE;
			PPBM_S_STROBE: begin
				next_s.xst = PPBM_S_END;
			end
			PPBM_S_END: begin
				// Sync delay: the second stage now holds the pins of the PPBM_S_ADDR cycle, the one before the strobe
				next_s.x_rdata = s.page_mode ? s.pin_s[2] : s.pin_s[0];
				next_s.x_done = 1'b1;
				next_s.xst = PPBM_S_IDLE;
			end
			default: next_s.xst = PPBM_S_IDLE;
		endcase
		bus_act = (next_s.xst != PPBM_S_IDLE);
		data_phase = (next_s.xst == PPBM_S_ADDR) || (next_s.xst == PPBM_S_STROBE);
		// Read strobe used for data reads only when both config bits are set
		read_strobe_sel = next_s.cfg_rd_lo & next_s.cfg_rd_hi;
		next_s.ale = (next_s.xst == PPBM_S_ALE);
		next_s.program_store_strobe_n_n = !((next_s.xst == PPBM_S_STROBE) && ((next_s.xr.kind == PPBM_XK_FETCH) ||
			((next_s.xr.kind == PPBM_XK_DREAD) && !read_strobe_sel)));
		next_s.rd_n = !((next_s.xst == PPBM_S_STROBE) && (next_s.xr.kind == PPBM_XK_DREAD) &&
			read_strobe_sel);
		next_s.wr_n = !((next_s.xst == PPBM_S_STROBE) && (next_s.xr.kind == PPBM_XK_DWRITE));
		// Address width: 8-bit leaves high byte to its latch
		case (next_s.xr.aw)
			PPBM_AW18: next_s.a_hi = next_s.xr.addr[17:16];
			PPBM_AW17: next_s.a_hi = {1'b0, next_s.xr.addr[16]};
			default: next_s.a_hi = 2'b00;
		endcase
		// Low-byte bus port
		if (bus_act) begin
			if (!next_s.page_mode && data_phase) begin
				next_s.p0_o = next_s.xr.wdata;
				next_s.p0_oe = (next_s.xr.kind == PPBM_XK_DWRITE) ? PPBM_ALL_ONES
					: PPBM_ALL_ZERO;
			end else begin
				next_s.p0_o = next_s.xr.addr[7:0];
				next_s.p0_oe = PPBM_ALL_ONES;
			end
			next_s.p0_pu = next_s.p0_o & next_s.p0_oe;
		end else begin
			// Open-drain: drive only zeros, never pull up
			next_s.p0_o = PPBM_ALL_ZERO;
			next_s.p0_oe = ~next_s.latch[0];
			next_s.p0_pu = PPBM_ALL_ZERO;
		end
		// High-byte bus port
		if (bus_act && (next_s.xr.aw != PPBM_AW8)) begin
			if (next_s.page_mode && data_phase) begin
				next_s.p2_o = next_s.xr.wdata;
				next_s.p2_oe = (next_s.xr.kind == PPBM_XK_DWRITE) ? PPBM_ALL_ONES
					: PPBM_ALL_ZERO;
			end else begin
				next_s.p2_o = next_s.xr.addr[15:8];
				next_s.p2_oe = PPBM_ALL_ONES;
			end
		end else begin
			next_s.p2_o = PPBM_ALL_ZERO;
			next_s.p2_oe = ~next_s.latch[2];
		end
		// Quasi ports: latch zero pulls down; latch one yields to alternate output
		next_s.p1_o = PPBM_ALL_ZERO;
		next_s.p3_o = PPBM_ALL_ZERO;
		// Drivers follow the registered latch, so pins move a cycle after it
		next_s.p1_adr = ~(s.latch[1] & ALT1_OUT_I);
		for (int i = 0; i < 4; i++) begin
			next_s.prev_latch[i] = next_s.latch[i];
		end
		for (int b = 0; b < PPBM_PORT_W; b++) begin
			for (int q = 0; q < 2; q++) begin
				if (next_s.latch[2 * q + 1][b] && !s.prev_latch[2 * q + 1][b]) begin
					next_s.xpu_cnt[q][b] = PPBM_XPU_LOAD;
				end else if (s.xpu_cnt[q][b] != 2'b00) begin
					next_s.xpu_cnt[q][b] = s.xpu_cnt[q][b] - 2'b01;
				end
				next_s.keeper[q][b] = s.pin_s[2 * q + 1][b];
			end
		end
		next_s.p3_adr = ~(s.latch[3] & ALT3_OUT_I);
		next_s.p1_xpu = {next_s.xpu_cnt[0][7] != 2'b00, next_s.xpu_cnt[0][6] != 2'b00,
			next_s.xpu_cnt[0][5] != 2'b00, next_s.xpu_cnt[0][4] != 2'b00,
			next_s.xpu_cnt[0][3] != 2'b00, next_s.xpu_cnt[0][2] != 2'b00,
			next_s.xpu_cnt[0][1] != 2'b00, next_s.xpu_cnt[0][0] != 2'b00};
		next_s.p3_xpu = {next_s.xpu_cnt[1][7] != 2'b00, next_s.xpu_cnt[1][6] != 2'b00,
			next_s.xpu_cnt[1][5] != 2'b00, next_s.xpu_cnt[1][4] != 2'b00,
			next_s.xpu_cnt[1][3] != 2'b00, next_s.xpu_cnt[1][2] != 2'b00,
			next_s.xpu_cnt[1][1] != 2'b00, next_s.xpu_cnt[1][0] != 2'b00};
		next_s.p1_keep = next_s.keeper[0] & next_s.latch[1];
		next_s.p3_keep = next_s.keeper[1] & next_s.latch[3];
	end

	always_ff @(posedge REF_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			s <= '0;
			s.latch <= {PPBM_NPORTS{PPBM_LATCH_RST}};
			s.prev_latch <= {PPBM_NPORTS{PPBM_LATCH_RST}};
			s.pin_m <= {PPBM_NPORTS{PPBM_ALL_ONES}};
			s.pin_s <= {PPBM_NPORTS{PPBM_ALL_ONES}};
			s.keeper <= {2{PPBM_ALL_ONES}};
			s.p1_keep <= PPBM_ALL_ONES;
			s.p3_keep <= PPBM_ALL_ONES;
			s.program_store_strobe_n_n <= 1'b1;
			s.rd_n <= 1'b1;
			s.wr_n <= 1'b1;
			s.xst <= PPBM_S_IDLE;
		end else if (CLK_EN_I) begin
			s <= next_s;
		end
	end

	// Quasi-port pins register one clock after the latch, so RMW results show next cycle; bus-port enables move with the latch
	assign LOW_BYTE_BUS_PORT_O = s.p0_o;
	assign LOW_BYTE_BUS_PORT_OE_O = s.p0_oe;
	assign LOW_BYTE_PULLUP_O = s.p0_pu;
	assign HIGH_BYTE_BUS_PORT_O = s.p2_o;
	assign HIGH_BYTE_BUS_PORT_OE_O = s.p2_oe;
	assign QUASI_PORT_ONE_O = s.p1_o;
	assign QUASI_PORT_ONE_OE_O = s.p1_adr;
	assign QUASI_ONE_TRANSITION_PULLUP_O = s.p1_xpu;
	assign QUASI_ONE_KEEPER_PULLUP_O = s.p1_keep;
	assign QUASI_PORT_THREE_O = s.p3_o;
	assign QUASI_PORT_THREE_OE_O = s.p3_adr;
	assign QUASI_THREE_TRANSITION_PULLUP_O = s.p3_xpu;
	assign QUASI_THREE_KEEPER_PULLUP_O = s.p3_keep;
	assign EXT_ADDR_HI_O = s.a_hi;
	assign ALE_O = s.ale;
	assign PROGRAM_STORE_STROBE_N_O = s.program_store_strobe_n_n;
	assign READ_STROBE_N_O = s.rd_n;
	assign WRITE_STROBE_N_O = s.wr_n;
	assign PORT_RDATA_O = s.rd_data;
	assign PORT_RVALID_O = s.rd_valid;
	assign XBUS_RDATA_O = s.x_rdata;
	assign XBUS_DONE_O = s.x_done;
	assign WB_DAT_O = s.wb_dat;
	assign WB_ACK_O = s.wb_ack;
endmodule : ppbm_top

//--- ppbm_properties.sv
// Concurrent checks on the ports of the parallel port and bus multiplexer.
// Assumes a bind to ppbm_top and one clock domain.
`timescale 1ns/1ps
module ppbm_props
	import ppbm_pkg::*;
(
	// Clock and reset
	input wire logic REF_CLK_I,
	input wire logic RESET_I,
	// Register bus
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	// External bus control
	input wire logic XBUS_DONE_O,
	input wire logic ALE_O,
	input wire logic PROGRAM_STORE_STROBE_N_O,
	input wire logic READ_STROBE_N_O,
	input wire logic WRITE_STROBE_N_O,
	// Pins
	input wire logic [7:0] LOW_BYTE_BUS_PORT_O,
	input wire logic [7:0] LOW_BYTE_BUS_PORT_OE_O,
	input wire logic [7:0] LOW_BYTE_PULLUP_O,
	input wire logic [7:0] HIGH_BYTE_BUS_PORT_O,
	input wire logic [7:0] HIGH_BYTE_BUS_PORT_OE_O,
	input wire logic [7:0] QUASI_ONE_TRANSITION_PULLUP_O
);
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RESET_I);
	AST_ACK_NEXT: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("ack missing");
	AST_BUS_SEQ: assert property (ALE_O |=> !ALE_O ##1 (!WRITE_STROBE_N_O || !READ_STROBE_N_O
		|| !PROGRAM_STORE_STROBE_N_O) ##1 (WRITE_STROBE_N_O && READ_STROBE_N_O
		&& PROGRAM_STORE_STROBE_N_O) ##1 XBUS_DONE_O) else $error("bus sequence");
	AST_DONE_CAUSE: assert property (XBUS_DONE_O |-> $past(ALE_O, 4))
		else $error("done without address phase");
	AST_ONE_STROBE: assert property ($onehot0({!WRITE_STROBE_N_O, !READ_STROBE_N_O,
		!PROGRAM_STORE_STROBE_N_O})) else $error("two strobes");
	AST_WR_HOLD: assert property (!WRITE_STROBE_N_O |-> $past(WRITE_STROBE_N_O)
		&& $stable(LOW_BYTE_BUS_PORT_O) && $stable(HIGH_BYTE_BUS_PORT_O)) else $error("wdata moved");
	AST_RD_HIZ: assert property (!READ_STROBE_N_O || !PROGRAM_STORE_STROBE_N_O |->
		LOW_BYTE_BUS_PORT_OE_O == 8'h00 || HIGH_BYTE_BUS_PORT_OE_O == 8'h00) else $error("no hi-z");
	AST_LB_PULLUP: assert property ((LOW_BYTE_PULLUP_O
		& ~(LOW_BYTE_BUS_PORT_O & LOW_BYTE_BUS_PORT_OE_O)) == 8'h00) else $error("pull-up");
	AST_XPU_TWO: assert property ($rose(QUASI_ONE_TRANSITION_PULLUP_O[0]) |=>
		QUASI_ONE_TRANSITION_PULLUP_O[0] ##1 !QUASI_ONE_TRANSITION_PULLUP_O[0]) else $error("xpu");
endmodule : ppbm_props
bind ppbm_top ppbm_props u_props (.REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .XBUS_DONE_O(XBUS_DONE_O),
	.ALE_O(ALE_O), .PROGRAM_STORE_STROBE_N_O(PROGRAM_STORE_STROBE_N_O),
	.READ_STROBE_N_O(READ_STROBE_N_O), .WRITE_STROBE_N_O(WRITE_STROBE_N_O),
	.LOW_BYTE_BUS_PORT_O(LOW_BYTE_BUS_PORT_O), .LOW_BYTE_BUS_PORT_OE_O(LOW_BYTE_BUS_PORT_OE_O),
	.LOW_BYTE_PULLUP_O(LOW_BYTE_PULLUP_O), .HIGH_BYTE_BUS_PORT_O(HIGH_BYTE_BUS_PORT_O),
	.HIGH_BYTE_BUS_PORT_OE_O(HIGH_BYTE_BUS_PORT_OE_O),
	.QUASI_ONE_TRANSITION_PULLUP_O(QUASI_ONE_TRANSITION_PULLUP_O));

//--- ppbm_ext.sv
// Pin level and external memory model for the port and bus multiplexer.
// Assumes open-drain port outputs; memory answers every read strobe.
`timescale 1ns/1ps
module ppbm_ext
	import ppbm_pkg::*;
#(
	parameter logic [7:0] MEM_BYTE = 8'h3C
)
(
	// Clock and bus control
	input wire logic clk_i,
	input wire logic ale_i,
	input wire logic strobe_n_i,
	// Device side of the pins
	input wire logic [7:0] lo_o_i,
	input wire logic [7:0] lo_oe_i,
	input wire logic [7:0] hi_o_i,
	input wire logic [7:0] hi_oe_i,
	input wire logic [7:0] q1_o_i,
	input wire logic [7:0] q1_oe_i,
	input wire logic [7:0] q1_ext_low_i,
	// Resolved pin levels
	output logic [7:0] lo_pin_o,
	output logic [7:0] hi_pin_o,
	output logic [7:0] q1_pin_o
);
	logic win = 1'b0;
	logic str_q = 1'b1;
	logic [7:0] lo_last = 8'h00;
	// Memory holds its byte until the cycle after the strobe is released
	always_ff @(posedge clk_i) begin
		str_q <= strobe_n_i;
		lo_last <= lo_pin_o;
		if (ale_i)
			win <= 1'b1;
		else if (strobe_n_i && !str_q)
			win <= 1'b0;
	end
	// Low-byte pins have no pull-up, so an undriven pin wanders
	assign lo_pin_o = (lo_oe_i & lo_o_i) | (~lo_oe_i & (win ? MEM_BYTE : ~lo_last));
	assign hi_pin_o = (hi_oe_i & hi_o_i) | (~hi_oe_i & (win ? MEM_BYTE : 8'hFF));
	assign q1_pin_o = (q1_oe_i & q1_o_i) | (~q1_oe_i & ~q1_ext_low_i);
endmodule : ppbm_ext

//--- ppbm_bench.sv
// Self-checking bench for the port and bus multiplexer.
// Assumes ppbm_ext for pins and memory; port three resolved here.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module ppbm_bench;
	import ppbm_pkg::*;
	localparam logic [7:0] MEMB = 8'h3C;
	logic clk, rst, cyc, we, pm, ack, rv, done, ale, ps_n, rd_n, wr_n;
	logic [4:0] adr;
	logic [31:0] wdat, rdat;
	logic [1:0] ahi;
	logic [7:0] alt1, low1, prd, xrd, got, lo_i, lo_o, lo_oe, q1_i, q1_o, q1_oe, q1_tp, q1_kp;
	logic [7:0] hi_i, hi_o, hi_oe, q3_i, q3_o, q3_oe;
	ppbm_req_t req;
	ppbm_xreq_t xr;
	int num_errors = 0;
	int n_compared = 0;
	assign q3_i = ~q3_oe | q3_o;
	ppbm_top uut (.REF_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(1'b1), .WB_CYC_I(cyc),
		.WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .PORT_REQ_I(req), .PORT_RDATA_O(prd),
		.PORT_RVALID_O(rv), .XBUS_REQ_I(xr), .PAGE_MODE_I(pm), .XBUS_RDATA_O(xrd),
		.XBUS_DONE_O(done), .ALT1_OUT_I(alt1), .ALT3_OUT_I(8'hFF), .LOW_BYTE_BUS_PORT_I(lo_i),
		.LOW_BYTE_BUS_PORT_O(lo_o), .LOW_BYTE_BUS_PORT_OE_O(lo_oe), .LOW_BYTE_PULLUP_O(),
		.QUASI_PORT_ONE_I(q1_i), .QUASI_PORT_ONE_O(q1_o), .QUASI_PORT_ONE_OE_O(q1_oe),
		.QUASI_ONE_TRANSITION_PULLUP_O(q1_tp), .QUASI_ONE_KEEPER_PULLUP_O(q1_kp),
		.HIGH_BYTE_BUS_PORT_I(hi_i), .HIGH_BYTE_BUS_PORT_O(hi_o), .HIGH_BYTE_BUS_PORT_OE_O(hi_oe),
		.QUASI_PORT_THREE_I(q3_i), .QUASI_PORT_THREE_O(q3_o), .QUASI_PORT_THREE_OE_O(q3_oe),
		.QUASI_THREE_TRANSITION_PULLUP_O(), .QUASI_THREE_KEEPER_PULLUP_O(), .EXT_ADDR_HI_O(ahi),
		.ALE_O(ale), .PROGRAM_STORE_STROBE_N_O(ps_n), .READ_STROBE_N_O(rd_n),
		.WRITE_STROBE_N_O(wr_n));
	ppbm_ext #(.MEM_BYTE(MEMB)) u_ext (.clk_i(clk), .ale_i(ale), .strobe_n_i(ps_n & rd_n),
		.lo_o_i(lo_o), .lo_oe_i(lo_oe), .hi_o_i(hi_o), .hi_oe_i(hi_oe), .q1_o_i(q1_o),
		.q1_oe_i(q1_oe), .q1_ext_low_i(low1), .lo_pin_o(lo_i), .hi_pin_o(hi_i), .q1_pin_o(q1_i));
	task automatic final_report;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	// Every task starts at a rising edge and ends at a falling one
	task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		for (i = 0; i < 9; i++) begin
			@(negedge clk);
			if (ack === 1'b1) break;
		end
		if (i == 9) begin
			num_errors++;
			final_report();
		end
		got = rdat[7:0];
		@(posedge clk);
		cyc <= 1'b0;
		@(negedge clk);
	endtask : wb
	task automatic pr(input ppbm_op_t op, input ppbm_alu_t al, input logic [2:0] b,
		input logic [7:0] d);
		@(posedge clk);
		req <= '{1'b1, op, 2'd1, b, 1'b0, al, d};
		@(posedge clk);
		req.valid <= 1'b0;
		@(negedge clk);
		got = prd;
		if (op != PPBM_OP_WRITE) `CHK("rvalid", 1'b1, rv)
	endtask : pr
	task automatic bx(input ppbm_xkind_t k, input ppbm_aw_t w, input logic [17:0] a,
		input logic [7:0] d, input logic [2:0] es, input logic p);
		int i;
		@(posedge clk);
		xr <= '{1'b1, k, w, a, d};
		pm <= p;
		@(posedge clk);
		xr.start <= 1'b0;
		for (i = 0; i < 12; i++) begin
			@(negedge clk);
			if (ale) begin
				`CHK("adr lo", a[7:0], lo_o)
				`CHK("adr hi", a[15:8], hi_o)
				`CHK("adr top", w == PPBM_AW18 ? a[17:16] : w == PPBM_AW17 ? {1'b0, a[16]} : 2'b00, ahi)
			end
			if ({ps_n, rd_n, wr_n} !== 3'b111) `CHK("strobe", es, ~{ps_n, rd_n, wr_n})
			if (wr_n === 1'b0) `CHK("wdata", d, p ? hi_o : lo_o)
			if (done === 1'b1) break;
		end
		if (i == 12) begin
			num_errors++;
			final_report();
		end
	endtask : bx
	task automatic t_reset;
		for (int p = 0; p < 4; p++) begin
			wb(1'b0, 5'(p * 4), 8'h00);
			`CHK("latch rst", PPBM_LATCH_RST, got)
		end
		wb(1'b1, 5'h14, 8'h12);
		wb(1'b0, 5'h14, 8'h00);
		`CHK("unmapped", 8'h00, got)
	endtask : t_reset
	task automatic t_latch;
		pr(PPBM_OP_WRITE, PPBM_RMW_LOAD, 3'd0, 8'h5A);
		wb(1'b0, PPBM_A_PORT1, 8'h00);
		`CHK("p1 latch", 8'h5A, got)
		`CHK("p1 oe", 8'hA5, q1_oe)
		@(posedge clk);
		alt1 <= 8'h0F;
		low1 <= 8'h10;
		repeat (3) @(negedge clk);
		`CHK("alt oe", 8'hF5, q1_oe)
		pr(PPBM_OP_RD_PIN, PPBM_RMW_LOAD, 3'd0, 8'h00);
		`CHK("pin rd", 8'h0A, got)
		@(posedge clk);
		alt1 <= 8'hFF;
		pr(PPBM_OP_RMW_BYTE, PPBM_RMW_AND, 3'd0, 8'hF0);
		`CHK("rmw and", 8'h5A, got)
		pr(PPBM_OP_RMW_BYTE, PPBM_RMW_OR, 3'd0, 8'h0F);
		`CHK("rmw or", 8'h50, got)
		pr(PPBM_OP_RMW_BYTE, PPBM_RMW_XOR, 3'd0, 8'hFF);
		`CHK("oe hold", 8'hA0, q1_oe)
		@(negedge clk);
		`CHK("oe late", 8'h5F, q1_oe)
		pr(PPBM_OP_RMW_BIT, PPBM_RMW_LOAD, 3'd7, 8'h00);
		wb(1'b0, PPBM_A_PORT1, 8'h00);
		`CHK("bit op", 8'h20, got)
	endtask : t_latch
	task automatic t_xpu;
		int n;
		n = 0;
		pr(PPBM_OP_WRITE, PPBM_RMW_LOAD, 3'd0, 8'h00);
		pr(PPBM_OP_WRITE, PPBM_RMW_LOAD, 3'd0, 8'hFF);
		repeat (6) begin
			if (q1_tp[0] === 1'b1) n++;
			@(negedge clk);
		end
		`CHK("xpu len", PPBM_XPU_CYC, n)
		`CHK("input again", PPBM_ALL_ZERO, q1_oe)
		`CHK("keeper", 8'hEF, q1_kp)
		@(posedge clk);
		low1 <= 8'h00;
		repeat (4) @(negedge clk);
		`CHK("keeper up", PPBM_ALL_ONES, q1_kp)
	endtask : t_xpu
	task automatic t_bus;
		wb(1'b1, PPBM_A_PORT0, 8'h00);
		wb(1'b1, PPBM_A_PORT2, 8'h77);
		bx(PPBM_XK_DWRITE, PPBM_AW16, 18'h01234, 8'hA5, 3'b001, 1'b0);
		wb(1'b0, PPBM_A_PORT0, 8'h00);
		`CHK("lo forced", PPBM_ALL_ONES, got)
		wb(1'b0, PPBM_A_PORT2, 8'h00);
		`CHK("hi kept", 8'h77, got)
		`CHK("hi idle", 8'h88, hi_oe)
		wb(1'b1, PPBM_A_CFG, 8'h06);
		bx(PPBM_XK_DREAD, PPBM_AW16, 18'h00456, 8'h00, 3'b010, 1'b0);
		`CHK("rd np", MEMB, xrd)
		wb(1'b1, PPBM_A_CFG, 8'h00);
		bx(PPBM_XK_DREAD, PPBM_AW17, 18'h1ABCD, 8'h00, 3'b100, 1'b0);
		bx(PPBM_XK_DWRITE, PPBM_AW16, 18'h00F0E, 8'h69, 3'b001, 1'b1);
		bx(PPBM_XK_FETCH, PPBM_AW18, 18'h2C3D4, 8'h00, 3'b100, 1'b1);
		`CHK("rd pg", MEMB, xrd)
	endtask : t_bus
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		{cyc, we, pm, adr, wdat, low1} = '0;
		alt1 = 8'hFF;
		req = '0;
		xr = '0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_latch();
		t_xpu();
		t_bus();
		final_report();
	end
endmodule : ppbm_bench
